// ===== shared/sldc_pkg.sv
// Shared constants and types for the serial line direction control block
package sldc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int FIFO_DEPTH = 32;
  localparam int IRQ_N = 8;
  localparam int PORT_IRQ_N = 6;
  localparam int IRQ_BUS = 7;
  localparam int IRQ_SHARED = 6;

  // ----------------------------------------------------------------
  // Character format and oversampling
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;

  // ----------------------------------------------------------------
  // Levels, strap encodings and reset values
  // ----------------------------------------------------------------
  localparam logic LINE_TX = 1'b0;
  localparam logic LINE_RX = 1'b1;
  localparam logic LINE_DIR_RST = LINE_RX;
  localparam logic STRAP_IRQ_RTC = 1'b0;
  localparam logic STRAP_IRQ_DIR = 1'b1;
  localparam logic WIRE_FOUR = 1'b0;
  localparam logic WIRE_TWO = 1'b1;
  localparam logic CONFIG_RUN = 1'b1;
  localparam logic [7:0] ADDR_HI_RST = 8'h00;
  localparam logic [7:0] PORT_OE_RST = 8'h00;
  localparam logic [7:0] VEC_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_START = 4'b0010,
    SER_DATA = 4'b0100,
    SER_STOP = 4'b1000
  } sldc_ser_e;

  typedef struct packed {
    logic nine_bits;
    logic [15:0] baud_div;
  } sldc_cfg_s;

  typedef struct packed {
    logic wr;
    logic [2:0] idx;
    logic [7:0] vec;
  } sldc_vec_wr_s;

  typedef struct packed {
    logic valid;
    logic [2:0] id;
    logic [7:0] vec;
  } sldc_irq_s;

endpackage

// ===== hdl/sldc_fifo.sv
// Transmit FIFO with valid and ready on both sides
`timescale 1ns/10ps
module sldc_fifo
  import sldc_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic in_ready;
    logic out_valid;
  } sldc_fifo_s;

  sldc_fifo_s s;
  sldc_fifo_s next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = i_in_valid && s.in_ready;
  assign pop = s.out_valid && i_out_ready;
  assign o_in_ready = s.in_ready;
  assign o_out_valid = s.out_valid;
  assign o_out_data = mem[s.rd];

  // Pointer and flag update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr = AW'(s.wr + 1'b1);
    end
    if (pop) begin
      next_s.rd = AW'(s.rd + 1'b1);
    end
    next_s.count = (AW+1)'(s.count + push - pop);
    next_s.in_ready = next_s.count != (AW+1)'(DEPTH);
    next_s.out_valid = next_s.count != '0;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s <= '{wr: '0, rd: '0, count: '0, in_ready: 1'b1, out_valid: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Storage
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[s.wr] <= i_in_data;
    end
  end

endmodule

// ===== hdl/sldc_irq_ctrl.sv
// External interrupt unit: enable, mask, priority and vector table
`timescale 1ns/10ps
module sldc_irq_ctrl
  import sldc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [IRQ_N-1:0] i_src_n,
  input wire logic i_global_en,
  input wire logic [IRQ_N-1:0] i_enable,
  input wire logic [IRQ_N-1:0] i_prio_high,
  input wire logic i_ack,
  input wire sldc_vec_wr_s i_vec_wr,
  output sldc_irq_s o_irq
);

  typedef struct packed {
    logic [IRQ_N-1:0] prev_n;
    logic [IRQ_N-1:0] pending;
    sldc_irq_s irq;
  } sldc_irq_ctrl_s;

  sldc_irq_ctrl_s s;
  sldc_irq_ctrl_s next_s;
  logic [7:0] vec_tab [IRQ_N];
  logic [IRQ_N-1:0] live;
  logic [IRQ_N-1:0] high;

  // Lowest index among set bits
  function automatic logic [2:0] first_set(input logic [IRQ_N-1:0] v);
    first_set = 3'h0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  assign live = s.pending & i_enable;
  assign high = live & i_prio_high;
  assign o_irq = s.irq;

  // Falling edge capture, ack clear, priority pick
  always_comb begin
    next_s = s;
    next_s.prev_n = i_src_n;
    if (i_ack && s.irq.valid) begin
      next_s.pending[s.irq.id] = 1'b0;
    end
    next_s.pending = next_s.pending | (s.prev_n & ~i_src_n); // set wins
    next_s.irq.valid = i_global_en && (live != '0);
    next_s.irq.id = (high != '0) ? first_set(high) : first_set(live);
    next_s.irq.vec = vec_tab[next_s.irq.id];
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s <= '{prev_n: '1, pending: '0, irq: '0};
    end else begin
      s <= next_s;
    end
  end

  // Vector table written by software
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < IRQ_N; i++) begin
        vec_tab[i] <= VEC_RST;
      end
    end else if (i_vec_wr.wr) begin
      vec_tab[i_vec_wr.idx] <= i_vec_wr.vec;
    end
  end

endmodule

// ===== hdl/sldc_top.sv
// Serial port with line direction control, interrupt routing and pins
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
module sldc_top
  import sldc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire sldc_cfg_s i_cfg,
  input wire logic [DATA_W-1:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [DATA_W-1:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_frame_err,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_dir_write,
  input wire logic i_dir_level,
  output logic o_line_dir,
  input wire logic i_wire_mode_strap,
  input wire logic i_irq_source_strap,
  input wire logic i_rtc_irq_n,
  input wire logic i_shared_port_pin_i,
  output logic o_shared_port_pin_o,
  output logic o_shared_port_pin_oe,
  output logic o_shared_ext_irq_n,
  input wire logic i_bus_ext_irq_n,
  input wire logic [PORT_IRQ_N-1:0] i_port_irq_n,
  input wire logic i_irq_global_en,
  input wire logic [IRQ_N-1:0] i_irq_enable,
  input wire logic [IRQ_N-1:0] i_irq_prio_high,
  input wire logic i_irq_ack,
  input wire sldc_vec_wr_s i_vec_wr,
  output sldc_irq_s o_irq,
  input wire logic [7:0] i_addr_hi,
  output logic [7:0] o_addr_hi,
  output logic o_addr_hi_oe,
  output logic o_analog_oe,
  input wire logic [7:0] i_port_oe,
  output logic [7:0] o_port_oe,
  input wire logic i_config_jumper,
  output logic o_config_run
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] baud_cnt;
    logic tick;
    sldc_ser_e tx_st;
    logic [3:0] tx_os;
    logic [3:0] tx_bit;
    logic [DATA_W-1:0] tx_sh;
    logic txd;
    sldc_ser_e rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_bit;
    logic [DATA_W-1:0] rx_sh;
    logic [DATA_W-1:0] rx_data;
    logic rx_valid;
    logic rx_ferr;
    logic line_dir;
    logic pin_o;
    logic pin_oe;
    logic shared_irq_n;
    logic [7:0] addr_hi;
    logic addr_hi_oe;
    logic [7:0] port_oe;
    logic config_run;
  } sldc_top_s;

  sldc_top_s s;
  sldc_top_s next_s;
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic rx_in;
  logic [3:0] nbits;
  logic [IRQ_N-1:0] irq_src_n;

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  assign fifo_pop = s.tx_st == SER_IDLE;

  sldc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_in_data(i_tx_data),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .o_out_data(fifo_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop)
  );

  // ----------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------
  assign irq_src_n[IRQ_BUS] = i_bus_ext_irq_n;
  assign irq_src_n[IRQ_SHARED] = s.shared_irq_n;
  assign irq_src_n[PORT_IRQ_N-1:0] = i_port_irq_n;

  sldc_irq_ctrl u_irq (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_src_n(irq_src_n),
    .i_global_en(i_irq_global_en),
    .i_enable(i_irq_enable),
    .i_prio_high(i_irq_prio_high),
    .i_ack(i_irq_ack),
    .i_vec_wr(i_vec_wr),
    .o_irq(o_irq)
  );

  // ----------------------------------------------------------------
  // Receive source and character length
  // ----------------------------------------------------------------
  // Shared two-wire line carries our own character back
  assign rx_in = (i_wire_mode_strap == WIRE_TWO && s.line_dir == LINE_TX)
                 ? s.txd : i_rxd;
  assign nbits = i_cfg.nine_bits ? BITS_NINE : BITS_EIGHT;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rx_valid = 1'b0;

    // Oversampling tick from configured divider
    next_s.tick = s.baud_cnt == i_cfg.baud_div;
    next_s.baud_cnt = next_s.tick ? 16'h0000 : 16'(s.baud_cnt + 1'b1);

    // Transmitter
    case (s.tx_st)
      SER_IDLE: begin
        if (fifo_valid) begin
          next_s.tx_sh = fifo_data;
          next_s.tx_os = 4'h0;
          next_s.tx_st = SER_START;
        end
      end
      SER_START: begin
        if (s.tick) begin
          next_s.tx_os = 4'(s.tx_os + 1'b1);
          if (s.tx_os == OS_LAST) begin
            next_s.tx_bit = 4'h0;
            next_s.tx_st = SER_DATA;
          end
        end
      end
      SER_DATA: begin
        if (s.tick) begin
          next_s.tx_os = 4'(s.tx_os + 1'b1);
          if (s.tx_os == OS_LAST) begin
            next_s.tx_sh = s.tx_sh >> 1;
            next_s.tx_bit = 4'(s.tx_bit + 1'b1);
            if (s.tx_bit == 4'(nbits - 1'b1)) begin
              next_s.tx_st = SER_STOP;
            end
          end
        end
      end
      SER_STOP: begin
        if (s.tick) begin
          next_s.tx_os = 4'(s.tx_os + 1'b1);
          if (s.tx_os == OS_LAST) begin
            next_s.tx_st = SER_IDLE;
          end
        end
      end
      default: begin
        next_s.tx_st = SER_IDLE;
      end
    endcase
    // Line level follows the next state
    case (next_s.tx_st)
      SER_START: next_s.txd = 1'b0;
      SER_DATA: next_s.txd = next_s.tx_sh[0];
      default: next_s.txd = 1'b1;
    endcase

    // Receiver, sampling at mid bit
    case (s.rx_st)
      SER_IDLE: begin
        if (!rx_in) begin
          next_s.rx_os = 4'h0;
          next_s.rx_st = SER_START;
        end
      end
      SER_START: begin
        if (s.tick) begin
          next_s.rx_os = 4'(s.rx_os + 1'b1);
          if (s.rx_os == OS_MID) begin
            next_s.rx_os = 4'h0;
            next_s.rx_bit = 4'h0;
            next_s.rx_st = rx_in ? SER_IDLE : SER_DATA;
          end
        end
      end
      SER_DATA: begin
        if (s.tick) begin
          next_s.rx_os = 4'(s.rx_os + 1'b1);
          if (s.rx_os == OS_LAST) begin
            next_s.rx_sh = {rx_in, s.rx_sh[DATA_W-1:1]};
            next_s.rx_bit = 4'(s.rx_bit + 1'b1);
            if (s.rx_bit == 4'(nbits - 1'b1)) begin
              next_s.rx_st = SER_STOP;
            end
          end
        end
      end
      SER_STOP: begin
        if (s.tick) begin
          next_s.rx_os = 4'(s.rx_os + 1'b1);
          if (s.rx_os == OS_LAST) begin
            // Eight-bit characters land in the upper bits
            next_s.rx_data = i_cfg.nine_bits ? s.rx_sh
                             : {1'b0, s.rx_sh[DATA_W-1:1]};
            next_s.rx_valid = 1'b1;
            next_s.rx_ferr = !rx_in;
            next_s.rx_st = SER_IDLE;
          end
        end
      end
      default: begin
        next_s.rx_st = SER_IDLE;
      end
    endcase

    // Direction is written by software only and then held
    if (i_dir_write) begin
      next_s.line_dir = i_dir_level;
    end

    // Shared pin: driven with direction or read as clock interrupt
    next_s.pin_oe = i_irq_source_strap == STRAP_IRQ_DIR;
    next_s.pin_o = next_s.line_dir;
    next_s.shared_irq_n = (i_irq_source_strap == STRAP_IRQ_RTC)
                          ? i_rtc_irq_n : i_shared_port_pin_i;

    // Port pins after reset
    next_s.addr_hi = i_addr_hi;
    next_s.addr_hi_oe = 1'b1;
    next_s.port_oe = i_port_oe;

    // Open jumper pulls high, which reads as run
    next_s.config_run = i_config_jumper == CONFIG_RUN;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s <= '{
        baud_cnt: 16'h0000,
        tick: 1'b0,
        tx_st: SER_IDLE,
        tx_os: 4'h0,
        tx_bit: 4'h0,
        tx_sh: '0,
        txd: 1'b1,
        rx_st: SER_IDLE,
        rx_os: 4'h0,
        rx_bit: 4'h0,
        rx_sh: '0,
        rx_data: '0,
        rx_valid: 1'b0,
        rx_ferr: 1'b0,
        line_dir: LINE_DIR_RST,
        pin_o: LINE_DIR_RST,
        pin_oe: 1'b0,
        shared_irq_n: 1'b1,
        addr_hi: ADDR_HI_RST,
        addr_hi_oe: 1'b1,
        port_oe: PORT_OE_RST,
        config_run: CONFIG_RUN
      };
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_txd = s.txd;
  assign o_rx_data = s.rx_data;
  assign o_rx_valid = s.rx_valid;
  assign o_rx_frame_err = s.rx_ferr;
  assign o_line_dir = s.line_dir;
  assign o_shared_port_pin_o = s.pin_o;
  assign o_shared_port_pin_oe = s.pin_oe;
  assign o_shared_ext_irq_n = s.shared_irq_n;
  assign o_addr_hi = s.addr_hi;
  assign o_addr_hi_oe = s.addr_hi_oe;
  assign o_analog_oe = 1'b0;
  assign o_port_oe = s.port_oe;
  assign o_config_run = s.config_run;

endmodule

// ===== verif/sldc_checker_assertions.sv
// Port relation checker for the serial line direction block
`timescale 1ns/10ps
module sldc_checker
  import sldc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_dir_write,
  input wire logic i_dir_level,
  input wire logic o_line_dir,
  input wire logic o_shared_port_pin_o,
  input wire logic o_shared_port_pin_oe,
  input wire logic i_irq_source_strap,
  input wire logic i_rtc_irq_n,
  input wire logic i_shared_port_pin_i,
  input wire logic o_shared_ext_irq_n,
  input wire logic [7:0] i_addr_hi,
  input wire logic [7:0] o_addr_hi,
  input wire logic o_addr_hi_oe,
  input wire logic o_analog_oe,
  input wire logic [7:0] i_port_oe,
  input wire logic [7:0] o_port_oe,
  input wire logic i_config_jumper,
  input wire logic o_config_run,
  input wire logic [PORT_IRQ_N-1:0] i_port_irq_n,
  input wire logic i_irq_global_en,
  input wire logic [IRQ_N-1:0] i_irq_enable,
  input wire logic [IRQ_N-1:0] i_irq_prio_high,
  input wire sldc_irq_s o_irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_dir_set;
    i_dir_write |=> o_line_dir == $past(i_dir_level);
  endproperty
  a_dir_set: assert property (p_dir_set)
    else $error("direction level not taken");
  property p_dir_hold;
    !i_dir_write |=> $stable(o_line_dir);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed without a write");
  property p_rst_state;
    $fell(i_rst) |-> o_line_dir == LINE_DIR_RST && !o_shared_port_pin_oe
      && o_addr_hi == ADDR_HI_RST && o_port_oe == PORT_OE_RST;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("wrong pin state at reset release");
  property p_pin_drive;
    1'b1 |=> o_shared_port_pin_oe == $past(i_irq_source_strap)
      && o_shared_port_pin_o == o_line_dir;
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("shared pin drive wrong");
  property p_route;
    1'b1 |=> o_shared_ext_irq_n == ($past(i_irq_source_strap) ?
      $past(i_shared_port_pin_i) : $past(i_rtc_irq_n));
  endproperty
  a_route: assert property (p_route)
    else $error("shared interrupt line routed wrong");
  property p_static;
    o_addr_hi_oe && !o_analog_oe;
  endproperty
  a_static: assert property (p_static)
    else $error("address or analog enable wrong");
  property p_copy;
    1'b1 |=> o_addr_hi == $past(i_addr_hi) && o_port_oe == $past(i_port_oe)
      && o_config_run == $past(i_config_jumper);
  endproperty
  a_copy: assert property (p_copy)
    else $error("pin copy wrong");
  property p_irq_gate;
    o_irq.valid |-> $past(i_irq_global_en);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt shown while globally off");
  property p_irq_first;
    !$past(i_rst) && $fell(i_port_irq_n[0]) && i_irq_global_en
      && i_irq_enable[0] && i_irq_prio_high[0]
      |-> ##2 o_irq.valid && o_irq.id == 3'h0;
  endproperty
  a_irq_first: assert property (p_irq_first)
    else $error("port interrupt zero not shown");
endmodule

bind sldc_top sldc_checker u_chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_dir_write(i_dir_write), .i_dir_level(i_dir_level),
  .o_line_dir(o_line_dir), .o_shared_port_pin_o(o_shared_port_pin_o),
  .o_shared_port_pin_oe(o_shared_port_pin_oe),
  .i_irq_source_strap(i_irq_source_strap), .i_rtc_irq_n(i_rtc_irq_n),
  .i_shared_port_pin_i(i_shared_port_pin_i),
  .o_shared_ext_irq_n(o_shared_ext_irq_n), .i_addr_hi(i_addr_hi),
  .o_addr_hi(o_addr_hi), .o_addr_hi_oe(o_addr_hi_oe),
  .o_analog_oe(o_analog_oe), .i_port_oe(i_port_oe), .o_port_oe(o_port_oe),
  .i_config_jumper(i_config_jumper), .o_config_run(o_config_run),
  .i_port_irq_n(i_port_irq_n), .i_irq_global_en(i_irq_global_en),
  .i_irq_enable(i_irq_enable), .i_irq_prio_high(i_irq_prio_high),
  .o_irq(o_irq));

// ===== verif/sldc_node.sv
// Remote serial node sending and receiving characters
`timescale 1ns/10ps
module sldc_node #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_line
);
  logic [8:0] got_q[$];
  logic [8:0] rx_ch;
  logic nine;
  int n;
  initial begin
    o_line = 1'b1;
    nine = 1'b0;
  end
  // Start, data low bit first, stop; idle high outside frames
  task automatic send(input logic [8:0] ch, input logic stop);
    o_line = 1'b0;
    repeat (BIT_CLKS) @(negedge i_clock);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      o_line = ch[i];
      repeat (BIT_CLKS) @(negedge i_clock);
    end
    o_line = stop;
    repeat (BIT_CLKS) @(negedge i_clock);
    o_line = 1'b1;
  endtask
  // Receiver sampling each data bit in its middle
  always begin
    @(negedge i_clock);
    if (i_line === 1'b0) begin
      rx_ch = '0;
      repeat (BIT_CLKS / 2) @(negedge i_clock);
      for (n = 0; n < (nine ? 9 : 8); n++) begin
        repeat (BIT_CLKS) @(negedge i_clock);
        rx_ch[n] = i_line;
      end
      repeat (BIT_CLKS) @(negedge i_clock);
      got_q.push_back(rx_ch);
    end
  end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the serial line direction block
`timescale 1ns/10ps
module tb_top;
  import sldc_pkg::*;
  logic clk, rst, tx_valid, tx_ready, rx_valid, rx_ferr, rxd, txd;
  logic dir_wr, dir_lvl, line_dir, wire_strap, src_strap, rtc_n;
  logic pin_i, pin_o, pin_oe, shared_n, bus_n, gen, ack;
  logic addr_oe, ana_oe, jumper, run;
  logic [8:0] tx_data, rx_data;
  logic [5:0] port_n;
  logic [7:0] irq_en, prio, addr_i, addr_o, poe_i, poe_o;
  sldc_cfg_s cfg;
  sldc_vec_wr_s vec_wr;
  sldc_irq_s irq;
  int n_fail = 0;
  int num_checks = 0;
  int rx_cnt = 0;
  int s;

  sldc_top dut (.i_clock(clk), .i_rst(rst), .i_cfg(cfg),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_frame_err(rx_ferr),
    .i_rxd(rxd), .o_txd(txd), .i_dir_write(dir_wr), .i_dir_level(dir_lvl),
    .o_line_dir(line_dir), .i_wire_mode_strap(wire_strap),
    .i_irq_source_strap(src_strap), .i_rtc_irq_n(rtc_n),
    .i_shared_port_pin_i(pin_i), .o_shared_port_pin_o(pin_o),
    .o_shared_port_pin_oe(pin_oe), .o_shared_ext_irq_n(shared_n),
    .i_bus_ext_irq_n(bus_n), .i_port_irq_n(port_n),
    .i_irq_global_en(gen), .i_irq_enable(irq_en), .i_irq_prio_high(prio),
    .i_irq_ack(ack), .i_vec_wr(vec_wr), .o_irq(irq), .i_addr_hi(addr_i),
    .o_addr_hi(addr_o), .o_addr_hi_oe(addr_oe), .o_analog_oe(ana_oe),
    .i_port_oe(poe_i), .o_port_oe(poe_o), .i_config_jumper(jumper),
    .o_config_run(run));
  sldc_node node (.i_clock(clk), .i_line(txd), .o_line(rxd));

  // Shared pin level: our drive when enabled, else pulled high
  assign pin_i = pin_oe ? pin_o : 1'b1;
  // Counts received characters
  always @(negedge clk) if (rx_valid === 1'b1) rx_cnt++;
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang(input string nm);
    n_fail++;
    $display("BAD %s exp done got timeout", nm);
    give_verdict();
  endtask
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_irq(input string nm, input sldc_irq_s e);
    num_checks++;
    if (irq !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, irq);
    end
  endtask
  function automatic sldc_irq_s mk(input logic [2:0] id, input logic [7:0] v);
    return '{1'b1, id, v};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wdir(input logic lvl);
    dir_wr = 1'b1;
    dir_lvl = lvl;
    cyc(1);
    dir_wr = 1'b0;
  endtask
  task automatic tx(input logic [8:0] w[$]);
    foreach (w[i]) begin
      tx_data = w[i];
      tx_valid = 1'b1;
      for (int k = 0; tx_ready !== 1'b1; k++) begin
        if (k == 100) hang("tx_ready");
        cyc(1);
      end
      cyc(1);
    end
    tx_valid = 1'b0;
  endtask
  task automatic wait_rx;
    for (int k = 0; k < 600; k++) begin
      cyc(1);
      if (rx_valid === 1'b1) return;
    end
    hang("rx_valid");
  endtask
  task automatic wait_node(input int cnt);
    for (int k = 0; node.got_q.size() < cnt; k++) begin
      if (k == 800) hang("node_rx");
      cyc(1);
    end
  endtask
  task automatic wait_irq;
    for (int k = 0; k < 8; k++) begin
      cyc(1);
      if (irq.valid === 1'b1) return;
    end
    hang("irq_valid");
  endtask
  task automatic src(input int i, input logic v);
    if (i < PORT_IRQ_N) port_n[i] = v;
    else if (i == IRQ_SHARED) rtc_n = v;
    else bus_n = v;
  endtask
  task automatic do_ack;
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(2);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; cfg = '0; tx_data = '0; tx_valid = 1'b0; dir_wr = 1'b0;
    dir_lvl = 1'b1; wire_strap = WIRE_FOUR; src_strap = STRAP_IRQ_RTC;
    rtc_n = 1'b1; bus_n = 1'b1; port_n = '1; gen = 1'b0; irq_en = '0;
    prio = '0; ack = 1'b0; vec_wr = '0; addr_i = 8'h5c; poe_i = 8'h3a;
    jumper = 1'b1;
    cyc(1);
    chk("line_dir", LINE_DIR_RST, line_dir);
    chk("addr_hi", ADDR_HI_RST, addr_o);
    chk("port_oe", PORT_OE_RST, poe_o);
    chk("oes", 9'h001, {ana_oe, addr_oe});
    cyc(1);
    rst = 1'b0;
    cyc(2);
    chk("run", CONFIG_RUN, run);
    jumper = 1'b0;
    cyc(2);
    chk("debug", !CONFIG_RUN, run);
    // Four-wire transmit, no echo expected
    wdir(LINE_TX);
    chk("dir_tx", LINE_TX, line_dir);
    tx('{9'h0a5, 9'h03c});
    wait_node(2);
    chk("tx0", 9'h0a5, node.got_q[0]);
    chk("tx1", 9'h03c, node.got_q[1]);
    chk("dir_hold", LINE_TX, line_dir);
    chk("no_echo", 9'h000, rx_cnt[8:0]);
    cfg.nine_bits = 1'b1;
    node.nine = 1'b1;
    tx('{9'h1c3});
    wait_node(3);
    chk("tx9", 9'h1c3, node.got_q[2]);
    wdir(LINE_RX);
    chk("dir_rx", LINE_RX, line_dir);
    fork
      node.send(9'h15a, 1'b1);
      wait_rx();
    join
    chk("rx9", 9'h15a, rx_data);
    cfg.nine_bits = 1'b0;
    node.nine = 1'b0;
    fork
      node.send(9'h05a, 1'b1);
      wait_rx();
    join
    chk("rx8", 9'h05a, rx_data);
    chk("ferr0", 9'h000, rx_ferr);
    fork
      node.send(9'h0c6, 1'b0);
      wait_rx();
    join
    chk("ferr1", 9'h001, rx_ferr);
    cyc(300);
    // Two-wire: transmitted character comes back
    wire_strap = WIRE_TWO;
    wdir(LINE_TX);
    tx('{9'h096});
    wait_rx();
    chk("echo", 9'h096, rx_data);
    wait_node(4);
    wdir(LINE_RX);
    // Every source with its own vector
    gen = 1'b1;
    irq_en = '1;
    prio = '1;
    for (s = 0; s < IRQ_N; s++) begin
      vec_wr = '{1'b1, s[2:0], 8'h40 + s[7:0]};
      cyc(1);
    end
    vec_wr = '0;
    for (s = 0; s < IRQ_N; s++) begin
      src(s, 1'b0);
      cyc(1);
      src(s, 1'b1);
      wait_irq();
      chk_irq("irq_src", mk(s[2:0], 8'h40 + s[7:0]));
      do_ack();
      chk("irq_clr", 9'h000, irq.valid);
    end
    prio = 8'h10;
    src(1, 1'b0);
    src(4, 1'b0);
    cyc(1);
    src(1, 1'b1);
    src(4, 1'b1);
    cyc(3);
    chk_irq("irq_prio", mk(3'h4, 8'h44));
    do_ack();
    chk_irq("irq_next", mk(3'h1, 8'h41));
    do_ack();
    irq_en[3] = 1'b0;
    src(3, 1'b0);
    cyc(1);
    src(3, 1'b1);
    cyc(4);
    chk("irq_mask", 9'h000, irq.valid);
    irq_en[3] = 1'b1;
    cyc(3);
    chk_irq("irq_unmask", mk(3'h3, 8'h43));
    do_ack();
    gen = 1'b0;
    src(2, 1'b0);
    cyc(1);
    src(2, 1'b1);
    cyc(4);
    chk("irq_off", 9'h000, irq.valid);
    gen = 1'b1;
    cyc(3);
    chk_irq("irq_on", mk(3'h2, 8'h42));
    do_ack();
    // Strap routing of the shared interrupt line
    src_strap = STRAP_IRQ_DIR;
    cyc(2);
    chk("pin_oe", 9'h001, pin_oe);
    wdir(LINE_TX);
    cyc(2);
    chk("shared_dir", LINE_TX, shared_n);
    wdir(LINE_RX);
    src_strap = STRAP_IRQ_RTC;
    rtc_n = 1'b0;
    cyc(2);
    chk("shared_rtc", 9'h000, shared_n);
    chk("pin_off", 9'h000, pin_oe);
    give_verdict();
  end
endmodule
